// [synth_port_consts.vh]
// constants shared by the serial programming port and its fractional divider
`ifndef SYNTH_PORT_CONSTS_VH
`define SYNTH_PORT_CONSTS_VH

// ****************************************
// serial word geometry
// ****************************************
`define WORD_W 24
`define WORD_MSB 23
`define ADDR_HI 23
`define ADDR_LO 22
`define ADDR_EXT 21

// ****************************************
// address codes
// ****************************************
`define ADDR_MAIN 2'h0
`define ADDR_REF 2'h1
`define ADDR_AUX 2'h2
`define ADDR_TEST_PAIR 2'h3
`define ADDR_TEST_EXT 1'h0

// ****************************************
// word kinds, one-hot, none as zero
// ****************************************
`define KIND_NONE 4'h0
`define KIND_MAIN 4'h1
`define KIND_REF 4'h2
`define KIND_AUX 4'h4
`define KIND_TEST 4'h8

// ****************************************
// main divider word fields
// ****************************************
`define MAIN_FM_BIT 21
`define MAIN_NF_HI 20
`define MAIN_NF_LO 18
`define MAIN_N_HI 17
`define MAIN_N_LO 2
`define MAIN_SK_HI 1
`define MAIN_SK_LO 0

// ****************************************
// reference/compensation word fields
// ****************************************
`define REF_R_HI 21
`define REF_R_LO 12
`define REF_L_HI 11
`define REF_L_LO 10
`define REF_PM_BIT 9
`define REF_PA_BIT 8
`define REF_FC_HI 7
`define REF_FC_LO 0

// ****************************************
// auxiliary and test payloads
// ****************************************
`define AUX_HI 21
`define TEST_HI 20

// ****************************************
// reset values
// ****************************************
`define RST_FM 1'h0
`define RST_NF 3'h2
`define RST_N 16'h2230
`define RST_SK 2'h0
`define RST_R 10'h051
`define RST_L 2'h0
`define RST_PM 1'h1
`define RST_PA 1'h1
`define RST_FC 8'h50
`define RST_AUX 22'h000000
`define RST_TEST 21'h000000

// ****************************************
// fractional accumulator
// ****************************************
`define MOD_FIVE 4'h5
`define MOD_EIGHT 4'h8
`define ACC_ZERO 3'h0
`define DIV_STEP 16'h0001
`define COUNT_END 16'h0000

`endif

// [frac_main_divider.v]
// fractional-n main divider with modulo 5/8 accumulator and synchronous ratio reload
`include "synth_port_consts.vh"

module frac_main_divider (
  input wire clk_in,              // core clock, stands for the prescaled input
  input wire rst_in,              // synchronous reset, active high
  input wire [15:0] ratio_in,     // programmed main divide ratio
  input wire mod_sel_in,          // 1 modulo five, 0 modulo eight
  input wire [2:0] inc_in,        // fractional increment
  output reg div_pulse_out,       // one-cycle pulse at end of each divider cycle
  output reg [2:0] acc_out,       // fractional accumulator contents
  output reg [15:0] active_ratio_out // ratio in use for the current cycle
);

  reg [15:0] count_q;
  reg mod_q;
  reg [2:0] inc_q;
  wire [3:0] modulus;
  wire [3:0] sum;
  wire ovf;
  wire [3:0] acc_next;

  assign modulus = mod_q ? `MOD_FIVE : `MOD_EIGHT;
  assign sum = {1'b0, acc_out} + {1'b0, inc_q};
  assign ovf = (sum >= modulus);
  assign acc_next = ovf ? (sum - modulus) : sum;

  // ****************************************
  // divider and accumulator
  // ****************************************
  // ratio, modulus and increment are only taken at the cycle boundary,
  // so a reload never cuts a division short
  always @(posedge clk_in) begin
    if (rst_in) begin
      count_q <= `RST_N - `DIV_STEP;
      active_ratio_out <= `RST_N;
      mod_q <= `RST_FM;
      inc_q <= `RST_NF;
      acc_out <= `ACC_ZERO;
      div_pulse_out <= 1'b0;
    end else begin
      div_pulse_out <= 1'b0;
      if (count_q == `COUNT_END) begin
        div_pulse_out <= 1'b1;
        active_ratio_out <= ratio_in;
        mod_q <= mod_sel_in;
        inc_q <= inc_in;
        // a stale residue could exceed the new modulus
        if (mod_sel_in != mod_q) begin
          acc_out <= `ACC_ZERO;
        end else begin
          acc_out <= acc_next[2:0];
        end
        if (ovf) begin
          count_q <= ratio_in;
        end else begin
          count_q <= ratio_in - `DIV_STEP;
        end
      end else begin
        count_q <= count_q - `DIV_STEP;
      end
    end
  end

endmodule

// [synth_serial_program_port.v]
// three-wire serial programming port with word decode and register bank
`include "synth_port_consts.vh"

module synth_serial_program_port (
  input wire CORE_CLK_IN,                 // core clock, 200 MHz
  input wire RST_IN,                      // synchronous reset, active high
  input wire SER_CLK_IN,                  // serial programming clock pin
  input wire SER_DATA_IN,                 // serial programming data pin
  input wire LATCH_EN_IN,                 // latch enable pin, active high
  output reg [15:0] MAIN_RATIO_OUT,       // programmed main divide ratio
  output reg FRACTION_MODULUS_SELECT_OUT, // 1 modulo five, 0 modulo eight
  output reg [2:0] FRACTION_INCREMENT_OUT,// fractional increment
  output reg [1:0] SPARE_BITS_OUT,        // spare bits hi, lo
  output reg [7:0] COMP_DAC_SETTING_OUT,  // working compensation dac value
  output reg [7:0] COMP_DAC_HELD_OUT,     // held compensation dac value
  output reg [9:0] REF_RATIO_OUT,         // reference divider ratio
  output reg [1:0] LOCK_MODE_OUT,         // lock detect output mode
  output reg MAIN_POWER_OUT,              // main loop powered
  output reg AUX_POWER_OUT,               // auxiliary loop powered
  output reg [21:0] AUX_WORD_OUT,         // auxiliary/charge-pump word payload
  output reg [20:0] TEST_WORD_OUT,        // test word payload
  output reg [3:0] WORD_KIND_OUT,         // kind of last latched word, one-hot, or zero if undecoded
  output reg SPEEDUP_OUT,                 // charge pump speed-up request
  output wire MAIN_DIV_PULSE_OUT,         // end of main divider cycle pulse
  output wire [2:0] FRAC_ACC_OUT,         // fractional accumulator contents
  output wire [15:0] ACTIVE_RATIO_OUT     // ratio in use by the divider
);

  // ****************************************
  // states of the serial front end
  // ****************************************
  localparam ST_SHIFT = 2'b01;
  localparam ST_FROZEN = 2'b10;

  // ****************************************
  // word decode
  // ****************************************
  // three address bits only matter for the test word; the extended
  // code not assigned to it decodes to nothing and is dropped
  function [3:0] word_kind;
    input [2:0] addr;
    begin
      case (addr[2:1])
        `ADDR_MAIN: word_kind = `KIND_MAIN;
        `ADDR_REF: word_kind = `KIND_REF;
        `ADDR_AUX: word_kind = `KIND_AUX;
        `ADDR_TEST_PAIR: begin
          if (addr[0] == `ADDR_TEST_EXT) begin
            word_kind = `KIND_TEST;
          end else begin
            word_kind = `KIND_NONE;
          end
        end
        default: word_kind = `KIND_NONE;
      endcase
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg sclk_s1_q;
  reg sclk_s2_q;
  reg sclk_s3_q;
  reg data_s1_q;
  reg data_s2_q;
  reg le_s1_q;
  reg le_s2_q;
  reg le_s3_q;
  wire sclk_rise;
  wire le_rise;
  wire le_fall;

  // all three pins share one latency, so data is seen aligned to its clock
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      data_s1_q <= 1'b0;
      data_s2_q <= 1'b0;
      le_s1_q <= 1'b0;
      le_s2_q <= 1'b0;
      le_s3_q <= 1'b0;
    end else begin
      sclk_s1_q <= SER_CLK_IN;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      data_s1_q <= SER_DATA_IN;
      data_s2_q <= data_s1_q;
      le_s1_q <= LATCH_EN_IN;
      le_s2_q <= le_s1_q;
      le_s3_q <= le_s2_q;
    end
  end

  assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
  assign le_rise = le_s2_q & ~le_s3_q;
  assign le_fall = ~le_s2_q & le_s3_q;

  // ****************************************
  // front end state
  // ****************************************
  reg [1:0] st_q;
  reg [1:0] st_d;

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_SHIFT: begin
        if (le_s2_q) begin
          st_d = ST_FROZEN;
        end
      end
      ST_FROZEN: begin
        if (!le_s2_q) begin
          st_d = ST_SHIFT;
        end
      end
      default: st_d = ST_SHIFT;
    endcase
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      st_q <= ST_SHIFT;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // shift register
  // ****************************************
  reg [23:0] shift_q;
  reg [23:0] shift_d;
  wire shifting;

  // a clock edge that meets the latch rise is already frozen out
  assign shifting = (st_q == ST_SHIFT) && !le_s2_q && sclk_rise;

  always @* begin
    shift_d = shift_q;
    if (shifting) begin
      // first bit in walks down to bit 0, last bit in stays on top
      shift_d = {data_s2_q, shift_q[`WORD_MSB:1]};
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      shift_q <= {`WORD_W{1'b0}};
    end else begin
      shift_q <= shift_d;
    end
  end

  // ****************************************
  // latch decode
  // ****************************************
  wire [3:0] latch_kind;
  wire take_main;
  wire take_ref;
  wire take_aux;
  wire take_test;

  assign latch_kind = word_kind(shift_q[`ADDR_HI:`ADDR_EXT]);
  assign take_main = le_rise && (latch_kind == `KIND_MAIN);
  assign take_ref = le_rise && (latch_kind == `KIND_REF);
  assign take_aux = le_rise && (latch_kind == `KIND_AUX);
  assign take_test = le_rise && (latch_kind == `KIND_TEST);

  // ****************************************
  // main divider word
  // ****************************************
  // ratio range is the host's concern; any value is stored as sent
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      MAIN_RATIO_OUT <= `RST_N;
      FRACTION_MODULUS_SELECT_OUT <= `RST_FM;
      FRACTION_INCREMENT_OUT <= `RST_NF;
      SPARE_BITS_OUT <= `RST_SK;
    end else if (take_main) begin
      MAIN_RATIO_OUT <= shift_q[`MAIN_N_HI:`MAIN_N_LO];
      FRACTION_MODULUS_SELECT_OUT <= shift_q[`MAIN_FM_BIT];
      FRACTION_INCREMENT_OUT <= shift_q[`MAIN_NF_HI:`MAIN_NF_LO];
      SPARE_BITS_OUT <= shift_q[`MAIN_SK_HI:`MAIN_SK_LO];
    end
  end

  // ****************************************
  // compensation dac, held then committed
  // ****************************************
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      COMP_DAC_HELD_OUT <= `RST_FC;
      COMP_DAC_SETTING_OUT <= `RST_FC;
    end else begin
      if (take_ref) begin
        COMP_DAC_HELD_OUT <= shift_q[`REF_FC_HI:`REF_FC_LO];
      end
      if (take_main) begin
        COMP_DAC_SETTING_OUT <= COMP_DAC_HELD_OUT;
      end
    end
  end

  // ****************************************
  // reference word, working fields
  // ****************************************
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      REF_RATIO_OUT <= `RST_R;
      LOCK_MODE_OUT <= `RST_L;
      MAIN_POWER_OUT <= `RST_PM;
      AUX_POWER_OUT <= `RST_PA;
    end else if (take_ref) begin
      REF_RATIO_OUT <= shift_q[`REF_R_HI:`REF_R_LO];
      LOCK_MODE_OUT <= shift_q[`REF_L_HI:`REF_L_LO];
      MAIN_POWER_OUT <= shift_q[`REF_PM_BIT];
      AUX_POWER_OUT <= shift_q[`REF_PA_BIT];
    end
  end

  // ****************************************
  // auxiliary and test words
  // ****************************************
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      AUX_WORD_OUT <= `RST_AUX;
      TEST_WORD_OUT <= `RST_TEST;
    end else begin
      if (take_aux) begin
        AUX_WORD_OUT <= shift_q[`AUX_HI:0];
      end
      if (take_test) begin
        TEST_WORD_OUT <= shift_q[`TEST_HI:0];
      end
    end
  end

  // ****************************************
  // latch bookkeeping and speed-up
  // ****************************************
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      WORD_KIND_OUT <= `KIND_NONE;
    end else if (le_rise) begin
      WORD_KIND_OUT <= latch_kind;
    end
  end

  // speed-up ends with the latch; a new main word while high cannot occur
  // because take_main needs a latch rise, which cannot come before le_fall
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      SPEEDUP_OUT <= 1'b0;
    end else if (le_fall) begin
      SPEEDUP_OUT <= 1'b0;
    end else if (take_main) begin
      SPEEDUP_OUT <= 1'b1;
    end
  end

  // ****************************************
  // fractional main divider
  // ****************************************
  frac_main_divider u_divider (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .ratio_in(MAIN_RATIO_OUT),
    .mod_sel_in(FRACTION_MODULUS_SELECT_OUT),
    .inc_in(FRACTION_INCREMENT_OUT),
    .div_pulse_out(MAIN_DIV_PULSE_OUT),
    .acc_out(FRAC_ACC_OUT),
    .active_ratio_out(ACTIVE_RATIO_OUT)
  );

endmodule

// [serial_host.sv]
// host model driving the three-wire serial programming bus
module serial_host (
  input wire logic clk_in, // core clock, paces the bus
  output logic sclk_out,   // serial clock, idles low
  output logic sdata_out,  // serial data
  output logic le_out      // latch enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    le_out = 1'b0;
  end
  // four core cycles a phase, well clear of the two-stage sync
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask
  task automatic pulse_clk(input logic d);
    sdata_out = d;
    half();
    sclk_out = 1'b1;
    half();
    sclk_out = 1'b0;
  endtask
  task automatic shift_bits(input logic [23:0] w, input int n);
    for (int i = 0; i < n; i++) pulse_clk(w[i]);
    sdata_out = ~sdata_out; // data no longer valid, so not the last bit
    half();
  endtask
  task automatic raise(input int junk);
    le_out = 1'b1;
    repeat (junk) pulse_clk(1'b1);
    half();
    half();
  endtask
  task automatic lower();
    le_out = 1'b0;
    half();
    half();
  endtask
endmodule

// [synth_serial_program_port_asserts.sv]
// assertions on the serial programming port outputs
`include "synth_port_consts.vh"

module synth_port_checker (
  input wire logic CORE_CLK_IN,                // core clock
  input wire logic RST_IN,                     // synchronous reset
  input wire logic LATCH_EN_IN,                // latch enable pin
  input wire logic [15:0] MAIN_RATIO_OUT,      // programmed ratio
  input wire logic [7:0] COMP_DAC_SETTING_OUT, // working dac
  input wire logic [7:0] COMP_DAC_HELD_OUT,    // held dac
  input wire logic [21:0] AUX_WORD_OUT,        // aux payload
  input wire logic [20:0] TEST_WORD_OUT,       // test payload
  input wire logic [3:0] WORD_KIND_OUT,        // last kind
  input wire logic SPEEDUP_OUT,                // speed-up
  input wire logic MAIN_DIV_PULSE_OUT,         // divider pulse
  input wire logic [15:0] ACTIVE_RATIO_OUT     // ratio in use
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  logic [16:0] gap_q;
  logic [16:0] len_q;
  logic armed_q;
  // first cycle after reset has no known start, so wait for a pulse
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      gap_q <= 17'h0;
      len_q <= 17'h0;
      armed_q <= 1'b0;
    end else if (MAIN_DIV_PULSE_OUT) begin
      gap_q <= 17'h1;
      len_q <= {1'b0, ACTIVE_RATIO_OUT};
      armed_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 17'h1;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  sequence s_le_settled;
    LATCH_EN_IN [*5] ##1 LATCH_EN_IN;
  endsequence
  sequence s_le_drop;
    $fell(LATCH_EN_IN);
  endsequence
  property p_kind_onehot;
    $onehot0(WORD_KIND_OUT);
  endproperty
  property p_frozen;
    s_le_settled |-> $stable(WORD_KIND_OUT) && $stable(MAIN_RATIO_OUT) && $stable(AUX_WORD_OUT);
  endproperty
  property p_aux_steer;
    !$stable(AUX_WORD_OUT) |-> WORD_KIND_OUT == `KIND_AUX && $past(LATCH_EN_IN, 3);
  endproperty
  property p_ratio_steer;
    !$stable(MAIN_RATIO_OUT) |-> WORD_KIND_OUT == `KIND_MAIN;
  endproperty
  property p_held_ref;
    !$stable(COMP_DAC_HELD_OUT) |-> WORD_KIND_OUT == `KIND_REF;
  endproperty
  property p_dac_commit;
    !$stable(COMP_DAC_SETTING_OUT) |->
      WORD_KIND_OUT == `KIND_MAIN && COMP_DAC_SETTING_OUT == $past(COMP_DAC_HELD_OUT);
  endproperty
  property p_test_kind;
    !$stable(TEST_WORD_OUT) |-> WORD_KIND_OUT == `KIND_TEST;
  endproperty
  property p_spd_set;
    $rose(SPEEDUP_OUT) |-> WORD_KIND_OUT == `KIND_MAIN && $past(LATCH_EN_IN, 3);
  endproperty
  property p_spd_hold;
    SPEEDUP_OUT && LATCH_EN_IN |=> SPEEDUP_OUT;
  endproperty
  property p_spd_clear;
    s_le_drop |-> ##[2:4] !SPEEDUP_OUT;
  endproperty
  property p_div_gap;
    MAIN_DIV_PULSE_OUT && armed_q |-> gap_q == len_q || gap_q == len_q + 17'h1;
  endproperty
  property p_div_early;
    armed_q && !MAIN_DIV_PULSE_OUT |-> gap_q <= len_q;
  endproperty
  // a ratio may only be swapped in at the divider's own boundary
  property p_ratio_sync;
    !$stable(ACTIVE_RATIO_OUT) |-> MAIN_DIV_PULSE_OUT;
  endproperty
  a_kind_onehot: assert property (p_kind_onehot) else $error("kind not one-hot");
  a_frozen: assert property (p_frozen) else $error("outputs moved during latch");
  a_aux_steer: assert property (p_aux_steer) else $error("aux word misrouted");
  a_ratio_steer: assert property (p_ratio_steer) else $error("ratio misrouted");
  a_held_ref: assert property (p_held_ref) else $error("held dac misrouted");
  a_dac_commit: assert property (p_dac_commit) else $error("dac commit wrong");
  a_test_kind: assert property (p_test_kind) else $error("test word misrouted");
  a_spd_set: assert property (p_spd_set) else $error("speed-up set wrongly");
  a_spd_hold: assert property (p_spd_hold) else $error("speed-up dropped early");
  a_spd_clear: assert property (p_spd_clear) else $error("speed-up not released");
  a_div_gap: assert property (p_div_gap) else $error("divider cycle length");
  a_div_early: assert property (p_div_early) else $error("divider cycle overrun");
  a_ratio_sync: assert property (p_ratio_sync) else $error("ratio reloaded mid-cycle");
endmodule

bind synth_serial_program_port synth_port_checker chk (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .LATCH_EN_IN(LATCH_EN_IN),
  .MAIN_RATIO_OUT(MAIN_RATIO_OUT), .COMP_DAC_SETTING_OUT(COMP_DAC_SETTING_OUT),
  .COMP_DAC_HELD_OUT(COMP_DAC_HELD_OUT), .AUX_WORD_OUT(AUX_WORD_OUT),
  .TEST_WORD_OUT(TEST_WORD_OUT), .WORD_KIND_OUT(WORD_KIND_OUT), .SPEEDUP_OUT(SPEEDUP_OUT),
  .MAIN_DIV_PULSE_OUT(MAIN_DIV_PULSE_OUT), .ACTIVE_RATIO_OUT(ACTIVE_RATIO_OUT)
);

// [synth_serial_program_port_tb.sv]
// self-checking bench for the serial programming port
`include "synth_port_consts.vh"

module synth_serial_program_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst;
  wire sclk, sdata, le, fm, pm, pa, spd, pulse;
  wire [15:0] main_ratio, act_ratio;
  wire [2:0] inc, acc;
  wire [1:0] spare, lock;
  wire [7:0] dac, held;
  wire [9:0] rref;
  wire [21:0] aux;
  wire [20:0] tw;
  wire [3:0] kind;
  int fail_count = 0;
  int total_checks = 0;
  logic [23:0] last_main, last_ref, last_aux, last_test;
  logic [7:0] exp_set, exp_held;
  logic [3:0] exp_kind;
  logic fms [3] = '{1'b0, 1'b1, 1'b0};
  logic [2:0] incs [3] = '{3'h0, 3'h4, 3'h7};

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  serial_host host (.clk_in(clk), .sclk_out(sclk), .sdata_out(sdata), .le_out(le));
  synth_serial_program_port DUT (
    .CORE_CLK_IN(clk), .RST_IN(rst), .SER_CLK_IN(sclk), .SER_DATA_IN(sdata),
    .LATCH_EN_IN(le), .MAIN_RATIO_OUT(main_ratio), .FRACTION_MODULUS_SELECT_OUT(fm),
    .FRACTION_INCREMENT_OUT(inc), .SPARE_BITS_OUT(spare), .COMP_DAC_SETTING_OUT(dac),
    .COMP_DAC_HELD_OUT(held), .REF_RATIO_OUT(rref), .LOCK_MODE_OUT(lock),
    .MAIN_POWER_OUT(pm), .AUX_POWER_OUT(pa), .AUX_WORD_OUT(aux), .TEST_WORD_OUT(tw),
    .WORD_KIND_OUT(kind), .SPEEDUP_OUT(spd), .MAIN_DIV_PULSE_OUT(pulse),
    .FRAC_ACC_OUT(acc), .ACTIVE_RATIO_OUT(act_ratio)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic model(input logic [23:0] w);
    case (w[23:22])
      2'h0: begin
        last_main = w;
        exp_set = exp_held;
        exp_kind = `KIND_MAIN;
      end
      2'h1: begin
        last_ref = w;
        exp_held = w[7:0];
        exp_kind = `KIND_REF;
      end
      2'h2: begin
        last_aux = w;
        exp_kind = `KIND_AUX;
      end
      default: begin
        if (!w[21]) last_test = w;
        exp_kind = w[21] ? `KIND_NONE : `KIND_TEST;
      end
    endcase
  endtask
  task automatic check_all();
    check("ratio", main_ratio, last_main[17:2]);
    check("fmod", fm, last_main[21]);
    check("incr", inc, last_main[20:18]);
    check("spare", spare, last_main[1:0]);
    check("dac_set", dac, exp_set);
    check("dac_held", held, exp_held);
    check("ref_ratio", rref, last_ref[21:12]);
    check("lock_mode", lock, last_ref[11:10]);
    check("power", {pm, pa}, last_ref[9:8]);
    check("aux", aux, last_aux[21:0]);
    check("test", tw, last_test[20:0]);
    check("kind", kind, exp_kind);
  endtask
  task automatic send(input logic [23:0] w, input int n, input int junk, input logic [23:0] m);
    host.shift_bits(w, n);
    host.raise(junk);
    model(m);
    check("speedup_on", spd, m[23:22] == 2'h0);
    host.lower();
    check("speedup_off", spd, 1'b0);
    check_all();
  endtask
  task automatic full(input logic [23:0] w);
    send(w, 24, 0, w);
  endtask
  task automatic wait_pulse(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pulse !== 1'b1 && n < 70000);
    if (n >= 70000) begin
      fail_count++;
      results();
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int k, n, sum, r, q, seed;
    logic [23:0] w, v;
    logic [3:0] e;
    rst = 1'b1;
    seed = $urandom(89145);
    last_main = {2'h0, `RST_FM, `RST_NF, `RST_N, `RST_SK};
    last_ref = {2'h1, `RST_R, `RST_L, `RST_PM, `RST_PA, `RST_FC};
    last_aux = 24'h0;
    last_test = 24'h0;
    exp_set = `RST_FC;
    exp_held = `RST_FC;
    exp_kind = `KIND_NONE;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    check_all();
    $display("test reset_defaults done");
    for (k = 0; k < 6; k++) begin
      r = (k == 0) ? 65535 : (k == 1) ? 512 : 512 + $urandom % 512;
      full({2'h2, 22'($urandom)});
      full({2'h1, 22'($urandom)});
      full({2'h0, 4'($urandom), r[15:0], 2'($urandom)});
    end
    $display("test config_order done");
    full({3'h6, 21'($urandom)});
    full({3'h7, 21'($urandom)});
    $display("test test_word done");
    v = {2'h2, 22'($urandom)};
    full(v);
    w = 24'($urandom);
    w[11:10] = 2'h1;
    send(w, 12, 0, {w[11:0], v[23:12]});
    $display("test short_transfer done");
    w = {2'h0, 4'($urandom), 16'h0200, 2'($urandom)};
    send(w, 24, 3, w);
    send(w, 0, 0, w);
    $display("test frozen_latch done");
    for (k = 0; k < 3; k++) begin
      r = 512 + $urandom % 64;
      q = fms[k] ? 5 : 8;
      full({2'h0, fms[k], incs[k], r[15:0], 2'h0});
      repeat (3) wait_pulse(n);
      check("active_ratio", act_ratio, r);
      // residue must stay below the selected modulus
      e = acc;
      check("acc_range", e < q, 1'b1);
      sum = 0;
      repeat (q) begin
        wait_pulse(n);
        sum += n;
        e = (e + incs[k]) % q;
        check("frac_acc", acc, e);
      end
      check("frac_span", sum, q * r + incs[k]);
    end
    $display("test fractional done");
    results();
  end

  // bound well above the longest divider wait
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
